// File: sfbl_alu.sv
// Result and flag calculator for one instruction
`timescale 1ns/10ps
`default_nettype none
module sfbl_alu
   import sfbl_pkg::*;
(
   sfbl_alu_if.alu bus
);
   logic [8:0] sum;
   logic [4:0] low_sum;

   // Subtract adds the inverted operand plus one, so carries mean no borrow
   always_comb begin
      if (bus.op == SFBL_OP_SUB) begin
         sum = {1'b0, bus.b} + {1'b0, ~bus.a} + 9'h001;
         low_sum = {1'b0, bus.b[3:0]} + {1'b0, ~bus.a[3:0]} + 5'h01;
      end else begin
         sum = {1'b0, bus.b} + {1'b0, bus.a};
         low_sum = {1'b0, bus.b[3:0]} + {1'b0, bus.a[3:0]};
      end
   end

   // Result, produced flags and which flags the operation owns
   always_comb begin
      bus.result = 8'h00;
      bus.flags = '0;
      bus.flag_mask = '0;
      unique case (bus.op)
         SFBL_OP_PASS_A: bus.result = bus.a;
         SFBL_OP_PASS_B: bus.result = bus.b;
         SFBL_OP_SWAP: bus.result = {bus.b[3:0], bus.b[7:4]};
         SFBL_OP_CLEAR: begin
            bus.result = 8'h00;
            bus.flag_mask = 3'h4;
         end
         SFBL_OP_ADD, SFBL_OP_SUB: begin
            bus.result = sum[7:0];
            bus.flags.half_nibble_out = low_sum[4];
            bus.flags.carry = sum[8];
            bus.flag_mask = 3'h7;
         end
         SFBL_OP_AND: begin
            bus.result = bus.a & bus.b;
            bus.flag_mask = 3'h4;
         end
         SFBL_OP_OR: begin
            bus.result = bus.a | bus.b;
            bus.flag_mask = 3'h4;
         end
         SFBL_OP_XOR: begin
            bus.result = bus.a ^ bus.b;
            bus.flag_mask = 3'h4;
         end
         SFBL_OP_ROT_RIGHT: begin
            bus.result = {bus.carry_in, bus.b[7:1]};
            bus.flags.carry = bus.b[0];
            bus.flag_mask = 3'h1;
         end
         SFBL_OP_ROT_LEFT: begin
            bus.result = {bus.b[6:0], bus.carry_in};
            bus.flags.carry = bus.b[7];
            bus.flag_mask = 3'h1;
         end
         default: bus.result = 8'h00;
      endcase
      bus.flags.zero = (bus.result == 8'h00);
   end
endmodule // sfbl_alu
`default_nettype wire

// File: sfbl_alu_if.sv
// Carrier between the core and its flag calculator
`timescale 1ns/10ps
`default_nettype none
interface sfbl_alu_if;
   import sfbl_pkg::*;
   sfbl_op_type op;
   logic [7:0] a;
   logic [7:0] b;
   logic carry_in;
   logic [7:0] result;
   sfbl_arith_type flags;
   sfbl_arith_type flag_mask;
   modport core (output op, a, b, carry_in, input result, flags, flag_mask);
   modport alu (input op, a, b, carry_in, output result, flags, flag_mask);
endinterface
`default_nettype wire

// File: sfbl_core.sv
// Status flag register and banked data memory decode with general and common RAM
`timescale 1ns/10ps
`default_nettype none
`include "sfbl_regs.svh"
module sfbl_core
   import sfbl_pkg::*;
#(
   parameter int GPR_BANKS = `SFBL_GPR_BANKS
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic por_rst,
   input wire logic instr_valid,
   input wire sfbl_op_type instr_op,
   input wire logic [7:0] instr_a,
   input wire logic [7:0] instr_b,
   input wire logic instr_to_file,
   input wire logic [`SFBL_ADDR_W-1:0] instr_addr,
   input wire logic watchdog_kick_instr,
   input wire logic sleep_instr,
   input wire logic watchdog_timer_expired,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic mem_linear,
   input wire logic [`SFBL_ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] ext_rdata,
   output logic [7:0] mem_rdata,
   output logic mem_rvalid,
   output logic [7:0] instr_result,
   output logic [7:0] status_flags,
   output logic ext_wr,
   output logic ext_is_periph,
   output logic [`SFBL_ADDR_W-1:0] ext_addr,
   output logic [7:0] ext_wdata
);
   localparam int GPR_TOTAL = GPR_BANKS * `SFBL_GPR_BYTES;
   localparam int GPR_IDX_W = $clog2(GPR_TOTAL);

   // Refuse RAM sizes the bank field cannot address
   if (GPR_BANKS < 1 || GPR_BANKS > `SFBL_NUM_BANKS) begin : g_bad_banks
      $error("sfbl_core: GPR_BANKS must lie between 1 and 32");
   end

   // Refuse a linear general RAM index wider than the data address
   if (GPR_IDX_W > `SFBL_ADDR_W) begin : g_bad_index
      $error("sfbl_core: general RAM index does not fit the data address");
   end

   // Status must sit among the core registers shared by every bank
   if (32'(`SFBL_STATUS_OFS) > 32'(`SFBL_CORE_LAST)) begin : g_bad_status
      $error("sfbl_core: status offset lies outside the core registers");
   end

   // Peripheral window must span its byte count directly after the core registers
   if (32'(`SFBL_PERIPH_LAST) - 32'(`SFBL_PERIPH_FIRST) + 1 != `SFBL_PERIPH_BYTES
         || 32'(`SFBL_PERIPH_FIRST) != 32'(`SFBL_CORE_LAST) + 1) begin : g_bad_periph
      $error("sfbl_core: peripheral window and byte count disagree");
   end

   // General RAM window must span its byte count directly after the peripherals
   if (32'(`SFBL_GPR_LAST) - 32'(`SFBL_GPR_FIRST) + 1 != `SFBL_GPR_BYTES
         || 32'(`SFBL_GPR_FIRST) != 32'(`SFBL_PERIPH_LAST) + 1) begin : g_bad_window
      $error("sfbl_core: general RAM window and byte count disagree");
   end

   // Common RAM closes the bank and is indexed by the low four offset bits
   if (`SFBL_COMMON_BYTES != 16
         || 32'(`SFBL_COMMON_FIRST) + `SFBL_COMMON_BYTES != (1 << `SFBL_OFS_W)) begin : g_bad_common
      $error("sfbl_core: common RAM layout does not close the bank");
   end

   sfbl_alu_if alu_bus ();

   // Status storage
   logic watchdog_expiry_n;
   logic sleep_entered_n;
   sfbl_arith_type arith;

   // Storage arrays
   logic [7:0] gpr_mem [GPR_TOTAL];
   logic [7:0] common_mem [`SFBL_COMMON_BYTES];

   // Write port selection
   logic wr_fire;
   logic wr_linear;
   logic [`SFBL_ADDR_W-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_flag_owned;
   sfbl_area_type wr_area;
   logic [GPR_IDX_W-1:0] wr_gpr_idx;
   logic [3:0] wr_common_idx;

   // Write strobes, merged low status bits and the accepted instruction
   logic status_store;
   logic gpr_store;
   logic common_store;
   logic ext_store;
   logic [2:0] stored_arith;
   logic instr_take;

   // Read port decode
   sfbl_area_type rd_area;
   logic [GPR_IDX_W-1:0] rd_gpr_idx;
   logic [3:0] rd_common_idx;
   logic [7:0] status_view;

   // Area of a banked address: bank in the top bits, offset below
   function automatic sfbl_area_type area_of(input logic [`SFBL_ADDR_W-1:0] addr);
      logic [`SFBL_OFS_W-1:0] ofs;
      logic [`SFBL_BANK_W-1:0] bank;
      ofs = addr[`SFBL_OFS_W-1:0];
      bank = addr[`SFBL_ADDR_W-1:`SFBL_OFS_W];
      if (ofs == `SFBL_STATUS_OFS) begin
         area_of = SFBL_AREA_STATUS;
      end else if (ofs <= `SFBL_CORE_LAST) begin
         area_of = SFBL_AREA_CORE;
      end else if (ofs <= `SFBL_PERIPH_LAST) begin
         area_of = SFBL_AREA_PERIPH;
      end else if (ofs <= `SFBL_GPR_LAST) begin
         if (32'(bank) < GPR_BANKS) begin
            area_of = SFBL_AREA_GPR;
         end else begin
            area_of = SFBL_AREA_NONE;
         end
      end else begin
         area_of = SFBL_AREA_COMMON;
      end
   endfunction

   // Flat general RAM index of a banked address
   function automatic logic [GPR_IDX_W-1:0] gpr_index(input logic [`SFBL_ADDR_W-1:0] addr);
      int idx;
      idx = 32'(addr[`SFBL_ADDR_W-1:`SFBL_OFS_W]) * `SFBL_GPR_BYTES
            + 32'(addr[`SFBL_OFS_W-1:0]) - 32'(`SFBL_GPR_FIRST);
      gpr_index = idx[GPR_IDX_W-1:0];
   endfunction

   // Linear accesses index the general RAM banks end to end
   function automatic sfbl_area_type linear_area(input logic [`SFBL_ADDR_W-1:0] addr);
      if (32'(addr) < GPR_TOTAL) begin
         linear_area = SFBL_AREA_GPR;
      end else begin
         linear_area = SFBL_AREA_NONE;
      end
   endfunction

   // Flag calculator feed
   assign alu_bus.op = instr_op;
   assign alu_bus.a = instr_a;
   assign alu_bus.b = instr_b;
   assign alu_bus.carry_in = arith.carry;

   sfbl_alu u_alu (
      .bus(alu_bus.alu)
   );

   // Only a completed instruction with a known operation acts; a stray code is dropped
   assign instr_take = instr_valid && (instr_op inside {SFBL_OP_PASS_A, SFBL_OP_PASS_B, SFBL_OP_CLEAR,
      SFBL_OP_ADD, SFBL_OP_SUB, SFBL_OP_AND, SFBL_OP_OR, SFBL_OP_XOR, SFBL_OP_ROT_RIGHT, SFBL_OP_ROT_LEFT,
      SFBL_OP_SWAP});

   // Instruction write wins over the memory port in the same cycle
   always_comb begin
      wr_fire = 1'b0;
      wr_linear = 1'b0;
      wr_addr = '0;
      wr_data = 8'h00;
      wr_flag_owned = 1'b0;
      if (instr_take && instr_to_file) begin
         wr_fire = 1'b1;
         wr_addr = instr_addr;
         wr_data = alu_bus.result;
         wr_flag_owned = (alu_bus.flag_mask != 3'h0);
      end else if (mem_wr) begin
         wr_fire = 1'b1;
         wr_linear = mem_linear;
         wr_addr = mem_addr;
         wr_data = mem_wdata;
      end
   end

   // Write target decode
   always_comb begin
      if (wr_linear) begin
         wr_area = linear_area(wr_addr);
         wr_gpr_idx = wr_addr[GPR_IDX_W-1:0];
      end else begin
         wr_area = area_of(wr_addr);
         wr_gpr_idx = gpr_index(wr_addr);
      end
      wr_common_idx = wr_addr[3:0];
   end

   // One strobe per write target; a flag-owning instruction stores nothing into status
   assign status_store = wr_fire && wr_area == SFBL_AREA_STATUS && !wr_flag_owned;
   assign gpr_store = wr_fire && wr_area == SFBL_AREA_GPR;
   assign common_store = wr_fire && wr_area == SFBL_AREA_COMMON;
   assign ext_store = wr_fire && (wr_area == SFBL_AREA_CORE || wr_area == SFBL_AREA_PERIPH);

   // Low status bits after a plain write, before the computed flags take their bits
   assign stored_arith = status_store ? wr_data[2:0] : arith;

   // Read target decode
   always_comb begin
      if (mem_linear) begin
         rd_area = linear_area(mem_addr);
         rd_gpr_idx = mem_addr[GPR_IDX_W-1:0];
      end else begin
         rd_area = area_of(mem_addr);
         rd_gpr_idx = gpr_index(mem_addr);
      end
      rd_common_idx = mem_addr[3:0];
   end

   // Status as seen by a read, top three bits fixed at zero
   assign status_view = {3'h0, watchdog_expiry_n, sleep_entered_n, arith};

   // Watchdog-expiry flag: expiry beats a kick or sleep in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         if (por_rst) begin
            watchdog_expiry_n <= `SFBL_POR_WDOG;
         end
      end else if (watchdog_timer_expired) begin
         watchdog_expiry_n <= 1'b0;
      end else if (watchdog_kick_instr || sleep_instr) begin
         watchdog_expiry_n <= 1'b1;
      end
   end

   // Sleep-entered flag: sleep beats a kick in the same cycle; no write path exists
   always_ff @(posedge clk) begin
      if (rst) begin
         if (por_rst) begin
            sleep_entered_n <= `SFBL_POR_SLEEP;
         end
      end else if (sleep_instr) begin
         sleep_entered_n <= 1'b0;
      end else if (watchdog_kick_instr) begin
         sleep_entered_n <= 1'b1;
      end
   end

   // Arithmetic flags: computed flags own their bits, a status write fills the rest
   always_ff @(posedge clk) begin
      if (rst) begin
         if (por_rst) begin
            arith <= `SFBL_POR_ARITH;
         end
      end else begin
         arith <= stored_arith;
         if (instr_take) begin
            if (alu_bus.flag_mask.zero) begin
               arith.zero <= alu_bus.flags.zero;
            end
            if (alu_bus.flag_mask.half_nibble_out) begin
               arith.half_nibble_out <= alu_bus.flags.half_nibble_out;
            end
            if (alu_bus.flag_mask.carry) begin
               arith.carry <= alu_bus.flags.carry;
            end
         end
      end
   end

   // Status mirror on the output
   always_ff @(posedge clk) begin
      if (rst) begin
         if (por_rst) begin
            status_flags <= {3'h0, `SFBL_POR_WDOG, `SFBL_POR_SLEEP, `SFBL_POR_ARITH};
         end
      end else begin
         status_flags <= 8'h00;
         status_flags[`SFBL_BIT_WDOG] <= watchdog_timer_expired ? 1'b0 :
            ((watchdog_kick_instr || sleep_instr) ? 1'b1 : watchdog_expiry_n);
         status_flags[`SFBL_BIT_SLEEP] <= sleep_instr ? 1'b0 :
            (watchdog_kick_instr ? 1'b1 : sleep_entered_n);
         status_flags[2:0] <= stored_arith;
         if (instr_take) begin
            status_flags[2:0] <= (alu_bus.flag_mask & alu_bus.flags) | (~alu_bus.flag_mask & stored_arith);
         end
      end
   end

   // General and common RAM writes
   always_ff @(posedge clk) begin
      if (gpr_store) begin
         gpr_mem[wr_gpr_idx] <= wr_data;
      end
      if (common_store) begin
         common_mem[wr_common_idx] <= wr_data;
      end
   end

   // Writes to peripheral and other core registers leave one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_wr <= 1'b0;
         ext_is_periph <= 1'b0;
         ext_addr <= '0;
         ext_wdata <= 8'h00;
      end else begin
         ext_wr <= ext_store;
         ext_is_periph <= wr_fire && wr_area == SFBL_AREA_PERIPH;
         if (wr_fire) begin
            ext_addr <= wr_addr;
            ext_wdata <= wr_data;
         end
      end
   end

   // Instruction result for the accumulator side
   always_ff @(posedge clk) begin
      if (rst) begin
         instr_result <= 8'h00;
      end else if (instr_take) begin
         instr_result <= alu_bus.result;
      end
   end

   // Read port: one cycle from request to data
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_rdata <= 8'h00;
         mem_rvalid <= 1'b0;
      end else begin
         mem_rvalid <= mem_rd;
         if (mem_rd) begin
            unique case (rd_area)
               SFBL_AREA_STATUS: mem_rdata <= status_view;
               SFBL_AREA_CORE, SFBL_AREA_PERIPH: mem_rdata <= ext_rdata;
               SFBL_AREA_GPR: mem_rdata <= gpr_mem[rd_gpr_idx];
               SFBL_AREA_COMMON: mem_rdata <= common_mem[rd_common_idx];
               SFBL_AREA_NONE: mem_rdata <= 8'h00;
               default: mem_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // sfbl_core
`default_nettype wire

// File: sfbl_core_asserts.sv
// Assertion checker for the status flags and bank layout block
`timescale 1ns/10ps
`default_nettype none
module sfbl_core_asserts
   import sfbl_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire sfbl_op_type instr_op,
   input wire logic [7:0] instr_a,
   input wire logic [7:0] instr_b,
   input wire logic watchdog_kick_instr,
   input wire logic sleep_instr,
   input wire logic watchdog_timer_expired,
   input wire logic mem_rd,
   input wire logic mem_rvalid,
   input wire logic [7:0] instr_result,
   input wire logic [7:0] status_flags
);
   // Add sums for the full byte and the low nibble
   logic [8:0] add_sum;
   logic [4:0] add_half;
   logic any_evt;
   assign add_sum = {1'b0, instr_a} + {1'b0, instr_b};
   assign add_half = {1'b0, instr_a[3:0]} + {1'b0, instr_b[3:0]};
   assign any_evt = watchdog_kick_instr | sleep_instr | watchdog_timer_expired;
   // All checks run on the core clock, idle in reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_upper_zero: assert property (status_flags[7:5] == 3'h0)
      else $error("status upper bits not zero");
   chk_add_flags: assert property (instr_valid && instr_op == SFBL_OP_ADD |=>
      status_flags[1:0] == {$past(add_half[4]), $past(add_sum[8])} && instr_result == $past(add_sum[7:0]))
      else $error("add result or carries wrong");
   chk_zero_logic: assert property (instr_valid && (instr_op == SFBL_OP_AND || instr_op == SFBL_OP_OR
      || instr_op == SFBL_OP_XOR) |=> status_flags[2] == (instr_result == 8'h00))
      else $error("zero flag does not follow result");
   chk_rot_carry: assert property (instr_valid && instr_op == SFBL_OP_ROT_RIGHT |=>
      status_flags[0] == $past(instr_b[0]))
      else $error("rotate right carry wrong");
   chk_read_pulse: assert property (1'b1 |=> mem_rvalid == $past(mem_rd))
      else $error("read valid not one cycle after read");
   chk_expiry_clear: assert property (watchdog_timer_expired |=> !status_flags[4])
      else $error("expiry flag not cleared");
   chk_sleep_bits: assert property (sleep_instr && !watchdog_timer_expired |=> status_flags[4:3] == 2'b10)
      else $error("sleep did not set expected bits");
   chk_kick_bits: assert property (watchdog_kick_instr && !sleep_instr && !watchdog_timer_expired
      |=> status_flags[4:3] == 2'b11)
      else $error("kick did not set both flags");
   chk_flag_hold: assert property (!any_evt |=> $stable(status_flags[4:3]))
      else $error("watchdog or sleep flag changed without event");
endmodule // sfbl_core_asserts
bind sfbl_core sfbl_core_asserts u_chk (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
   .instr_a(instr_a), .instr_b(instr_b), .watchdog_kick_instr(watchdog_kick_instr), .sleep_instr(sleep_instr),
   .watchdog_timer_expired(watchdog_timer_expired), .mem_rd(mem_rd), .mem_rvalid(mem_rvalid),
   .instr_result(instr_result), .status_flags(status_flags));
`default_nettype wire

// File: sfbl_cpu_model.sv
// CPU-side model: completed instructions, watchdog events, outside register data
`timescale 1ns/10ps
`default_nettype none
module sfbl_cpu_model
   import sfbl_pkg::*;
(
   input wire logic clk,
   input wire logic mem_rd,
   input wire logic [11:0] mem_addr,
   output logic instr_valid,
   output sfbl_op_type instr_op,
   output logic [7:0] instr_a,
   output logic [7:0] instr_b,
   output logic instr_to_file,
   output logic [11:0] instr_addr,
   output logic kick,
   output logic slp,
   output logic expd,
   output logic [7:0] ext_rdata
);
   logic [7:0] noise = 8'h00;
   // Idle values from time zero
   initial begin
      {instr_valid, instr_to_file, kick, slp, expd} = 5'h00;
      {instr_a, instr_b, instr_addr} = 28'h0;
      instr_op = SFBL_OP_PASS_A;
   end
   // Outside registers answer a read; otherwise the line keeps moving
   assign ext_rdata = mem_rd ? {mem_addr[3:0], ~mem_addr[3:0]} : noise;
   always @(posedge clk) noise <= noise + 8'h01;
   // One instruction completes for a single cycle
   task exec(input sfbl_op_type op, input logic [7:0] a, b, input logic tf, input logic [11:0] ad);
      @(negedge clk);
      {instr_valid, instr_a, instr_b, instr_to_file, instr_addr} = {1'b1, a, b, tf, ad};
      instr_op = op;
      @(negedge clk);
      {instr_valid, instr_a, instr_b} = {1'b0, ~a, ~b};
   endtask
   // Kick, sleep and expiry pulses for a single cycle
   task events(input logic [2:0] e);
      @(negedge clk);
      {kick, slp, expd} = e;
      @(negedge clk);
      {kick, slp, expd} = 3'h0;
   endtask
endmodule // sfbl_cpu_model
`default_nettype wire

// File: sfbl_pkg.sv
// Types shared by the status flags and bank layout block
package sfbl_pkg;
   // Operation performed for one completed instruction
   typedef enum logic [3:0] {
      SFBL_OP_PASS_A,
      SFBL_OP_PASS_B,
      SFBL_OP_CLEAR,
      SFBL_OP_ADD,
      SFBL_OP_SUB,
      SFBL_OP_AND,
      SFBL_OP_OR,
      SFBL_OP_XOR,
      SFBL_OP_ROT_RIGHT,
      SFBL_OP_ROT_LEFT,
      SFBL_OP_SWAP
   } sfbl_op_type;
   // Arithmetic flags in status order: zero, half_nibble_out, carry
   typedef struct packed {
      logic zero;
      logic half_nibble_out;
      logic carry;
   } sfbl_arith_type;
   // Where a data memory access lands
   typedef enum logic [2:0] {
      SFBL_AREA_STATUS,
      SFBL_AREA_CORE,
      SFBL_AREA_PERIPH,
      SFBL_AREA_GPR,
      SFBL_AREA_COMMON,
      SFBL_AREA_NONE
   } sfbl_area_type;
endpackage

// File: sfbl_regs.svh
// Offsets, field positions, reset values and sizes of the status flags and bank layout block
`ifndef SFBL_REGS_SVH
`define SFBL_REGS_SVH
`define SFBL_ADDR_W 12
`define SFBL_OFS_W 7
`define SFBL_BANK_W 5
`define SFBL_STATUS_OFS 7'h03
`define SFBL_CORE_LAST 7'h0B
`define SFBL_PERIPH_FIRST 7'h0C
`define SFBL_PERIPH_LAST 7'h1F
`define SFBL_PERIPH_BYTES 20
`define SFBL_GPR_FIRST 7'h20
`define SFBL_GPR_LAST 7'h6F
`define SFBL_COMMON_FIRST 7'h70
`define SFBL_GPR_BYTES 80
`define SFBL_COMMON_BYTES 16
`define SFBL_GPR_BANKS 3
`define SFBL_NUM_BANKS 32
`define SFBL_BIT_WDOG 4
`define SFBL_BIT_SLEEP 3
`define SFBL_BIT_ZERO 2
`define SFBL_BIT_HALF 1
`define SFBL_BIT_CARRY 0
`define SFBL_POR_WDOG 1'h1
`define SFBL_POR_SLEEP 1'h1
`define SFBL_POR_ARITH 3'h0
`endif

// File: tb_top.sv
// Self-checking bench for the status flags and bank layout block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sfbl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, por_rst = 1'b1, mem_rd = 1'b0, mem_wr = 1'b0, mem_linear = 1'b0;
   logic [11:0] mem_addr = 12'h000, ext_addr, instr_addr;
   logic [7:0] mem_wdata = 8'h00, ext_rdata, mem_rdata, instr_result, status_flags, ext_wdata, instr_a, instr_b;
   logic mem_rvalid, ext_wr, ext_is_periph, instr_valid, instr_to_file, kick, slp, expd;
   sfbl_op_type instr_op;
   int errors = 0, checked = 0, idx;
   logic [7:0] st, d;
   logic [10:0] x;
   // Core clock, 20 ns
   always #10 clk = ~clk;
   sfbl_cpu_model cpu (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_a(instr_a), .instr_b(instr_b), .instr_to_file(instr_to_file),
      .instr_addr(instr_addr), .kick(kick), .slp(slp), .expd(expd), .ext_rdata(ext_rdata));
   sfbl_core #(.GPR_BANKS(3)) dut (.clk(clk), .rst(rst), .por_rst(por_rst), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_a(instr_a), .instr_b(instr_b), .instr_to_file(instr_to_file),
      .instr_addr(instr_addr), .watchdog_kick_instr(kick), .sleep_instr(slp), .watchdog_timer_expired(expd),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_linear(mem_linear), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .ext_rdata(ext_rdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .instr_result(instr_result),
      .status_flags(status_flags), .ext_wr(ext_wr), .ext_is_periph(ext_is_periph), .ext_addr(ext_addr),
      .ext_wdata(ext_wdata));
   // Compare and count
   task chk(input string n, input logic [7:0] e, g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task report_and_stop;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Expected result and zero, half, carry flags from the old flags
   function automatic logic [10:0] alu(sfbl_op_type op, logic [7:0] a, b, logic [2:0] f);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, b};
      h = {4'h0, f[1]};
      case (op)
         SFBL_OP_PASS_A: s[7:0] = a;
         SFBL_OP_CLEAR: s[7:0] = 8'h00;
         SFBL_OP_ADD: {s, h} = {9'({1'b0, a} + b), 5'({1'b0, a[3:0]} + b[3:0])};
         SFBL_OP_SUB: {s, h} = {1'(b >= a), 8'(b - a), 1'(b[3:0] >= a[3:0]), 4'(b[3:0] - a[3:0])};
         SFBL_OP_AND: s[7:0] = a & b;
         SFBL_OP_OR: s[7:0] = a | b;
         SFBL_OP_XOR: s[7:0] = a ^ b;
         SFBL_OP_ROT_RIGHT: s = {b[0], f[0], b[7:1]};
         SFBL_OP_ROT_LEFT: s = {b[7], b[6:0], f[0]};
         SFBL_OP_SWAP: s[7:0] = {b[3:0], b[7:4]};
         default: s[7:0] = b;
      endcase
      if (op inside {SFBL_OP_PASS_A, SFBL_OP_PASS_B, SFBL_OP_SWAP})
         return {s[7:0], f};
      if (op inside {SFBL_OP_ROT_RIGHT, SFBL_OP_ROT_LEFT})
         return {s[7:0], f[2:1], s[8]};
      if (op inside {SFBL_OP_ADD, SFBL_OP_SUB})
         return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
      return {s[7:0], s[7:0] == 8'h00, f[1:0]};
   endfunction
   // One instruction and its expected outcome
   task run(input sfbl_op_type op, input logic [7:0] a, b, input logic tf, input logic [11:0] ad);
      cpu.exec(op, a, b, tf, ad);
      x = alu(op, a, b, st[2:0]);
      if (tf && ad[6:0] == 7'h03 && op inside {SFBL_OP_PASS_A, SFBL_OP_PASS_B, SFBL_OP_SWAP})
         x[2:0] = x[5:3];
      st[2:0] = x[2:0];
      chk("result", x[10:3], instr_result);
      chk("status", st, status_flags);
   endtask
   // One memory port access, read data compared
   task acc(input logic rd, wr, lin, input logic [11:0] ad, input logic [7:0] wd, e);
      @(negedge clk);
      {mem_rd, mem_wr, mem_linear, mem_addr, mem_wdata} = {rd, wr, lin, ad, wd};
      @(negedge clk);
      {mem_rd, mem_wr, mem_wdata} = {2'b00, ~wd};
      if (rd)
         chk("read data", e, mem_rdata);
      chk("read valid", {7'h00, rd}, {7'h00, mem_rvalid});
   endtask
   // Hang guard
   initial begin
      #1000000;
      errors++;
      report_and_stop;
   end
   // Main sequence
   initial begin
      void'($urandom(32'h95ADCB2B));
      repeat (6) @(negedge clk);
      rst = 1'b0;
      st = 8'h18;
      chk("power-on status", st, status_flags);
      for (int i = 0; i < 60; i++)
         run(sfbl_op_type'($urandom_range(0, 10)), 8'($urandom), 8'($urandom), 1'($urandom), {5'($urandom), 7'h03});
      run(SFBL_OP_ADD, 8'h08, 8'h08, 1'b0, 12'h000);
      run(SFBL_OP_SUB, 8'h01, 8'h00, 1'b0, 12'h000);
      run(SFBL_OP_SUB, 8'h05, 8'h05, 1'b0, 12'h000);
      run(SFBL_OP_PASS_A, 8'hFF, 8'h00, 1'b1, 12'h283);
      run(SFBL_OP_CLEAR, 8'h00, 8'h00, 1'b1, 12'h003);
      run(SFBL_OP_ADD, 8'hFF, 8'h01, 1'b1, 12'h003);
      run(SFBL_OP_ROT_LEFT, 8'h00, 8'h80, 1'b0, 12'h000);
      for (int e = 0; e < 8; e++) begin
         cpu.events(3'(e));
         if (e[0])
            st[4] = 1'b0;
         else if (e[2:1] != 2'b00)
            st[4] = 1'b1;
         if (e[1])
            st[3] = 1'b0;
         else if (e[2])
            st[3] = 1'b1;
         chk("watchdog bits", st, status_flags);
      end
      @(negedge clk);
      {rst, por_rst} = 2'b10;
      @(negedge clk);
      rst = 1'b0;
      chk("other reset", st, status_flags);
      acc(1'b1, 1'b0, 1'b0, 12'h283, 8'h00, st);
      acc(1'b1, 1'b0, 1'b0, 12'h31F, 8'h00, 8'hF0);
      acc(1'b0, 1'b1, 1'b0, 12'h10C, 8'h3C, 8'h00);
      chk("periph write", 8'h3C, {ext_wr, ext_is_periph, ext_addr[5:0]} ^ ext_wdata ^ 8'hCC);
      acc(1'b0, 1'b1, 1'b0, 12'h208, 8'h44, 8'h00);
      chk("core write", 8'h88, {ext_wr, ext_is_periph, ext_addr[5:0]});
      acc(1'b0, 1'b1, 1'b0, 12'h070, 8'h5A, 8'h00);
      acc(1'b1, 1'b0, 1'b0, 12'h3F0, 8'h00, 8'h5A);
      acc(1'b0, 1'b1, 1'b1, 12'd239, 8'h77, 8'h00);
      acc(1'b1, 1'b0, 1'b0, 12'h16F, 8'h00, 8'h77);
      for (int k = 0; k < 8; k++) begin
         idx = $urandom_range(0, 239);
         d = 8'($urandom);
         acc(1'b0, 1'b1, 1'b0, {5'(idx / 80), 7'(idx % 80 + 32)}, d, 8'h00);
         acc(1'b1, 1'b0, 1'b1, 12'(idx), 8'h00, d);
      end
      acc(1'b0, 1'b1, 1'b0, 12'h1A0, 8'h11, 8'h00);
      acc(1'b1, 1'b0, 1'b0, 12'h1A0, 8'h00, 8'h00);
      acc(1'b1, 1'b0, 1'b1, 12'd240, 8'h00, 8'h00);
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
